/* File: cbr_regs.sv */
// What this block does
// R1: Interrupt line byte stores host value, resets FFh.
// R2: CardBus interrupt pin always reads INTA code.
// R3: Tie-B bit merges interrupt B onto A.
// R4: Tie-all merges A-D onto A; smart pin INTA.
// R5: Otherwise smart pin follows its select field.
// R6: Bridge control resets 0340h; reserved bits zero.
// R7: Bit 10 enables posting of burst writes.
// R8: Bits 9,8 mark windows 1,0 prefetchable.
// R9: Bit 7 routes card interrupts to legacy IRQ.
// R10: Bit 6 drives the card reset output.
// R11: Bus reset input also drives card reset.
// R12: Reset bit survives bus reset while POWER_MGMT_EVENT on.
// R13: Bit 5 reports master aborts as target abort.
// R14: Bit 3 forwards VGA addresses to the card.
// R15: Bit 2 blocks ISA alias I/O cycles.
// R16: Bit 1 forwards card system error upstream.
// R17: Bit 0 reports card parity errors.
// R18: Windows claim only when base or limit nonzero.
// R19: Writes to read-only bits are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "cbr_consts.svh"

module cbr_regs
  import cbr_pkg::*;
(
  input  wire logic         clk_i,                // Bus clock
  input  wire logic         nrst_i,               // Global reset
  input  wire logic         pci_reset_in_n_i,     // Bus reset pin
  input  wire cbr_cfg_req_s cfg_req_i,            // Config access
  output logic [31:0]       cfg_rdata_o,          // Read data
  output logic              cfg_ack_o,            // Access done
  input  wire logic         tie_b_to_a_i,         // Tie B onto A
  input  wire logic         tie_all_interrupts_i, // Tie all onto A
  input  wire logic [1:0]   smart_int_sel_i,      // Smart card select
  input  wire logic         pme_enable_i,         // POWER_MGMT_EVENT enabled
  input  wire logic [3:0]   int_src_i,            // Sources A..D
  input  wire logic         func_irq_i,           // Card func irq
  output logic [3:0]        pci_int_o,            // Merged A..D
  output logic              legacy_irq_o,         // Legacy path irq
  output logic [7:0]        interrupt_pin_code_o, // Smart card pin
  output logic              cardbus_reset_out_n_o,// Card reset
  input  wire logic         burst_write_i,        // Burst write seen
  output logic              post_write_o,         // Post this write
  output logic [1:0]        window_prefetch_o,    // Win1, win0 type
  input  wire logic         master_abort_i,       // Abort as master
  input  wire logic         serr_enable_i,        // Command SERR en
  output logic              target_abort_o,       // Target abort pulse
  output logic              pci_serr_o,           // System error pulse
  input  wire logic         card_system_error_n_i,// Card SERR pin
  input  wire logic         parity_err_det_i,     // Parity fault seen
  output logic              card_parity_error_o,  // Parity pin level
  output logic              card_parity_error_oe_o,// Parity pin drive
  input  wire cbr_access_s  acc_i,                // Access to decode
  input  wire cbr_window_s  win0_i,               // Memory window 0
  input  wire cbr_window_s  win1_i,               // Memory window 1
  output logic              claim_o               // Access claimed
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Three stages each; the first stage feeds only the second
  logic [2:0] pci_reset_in_sync_q, pci_reset_in_sync_d;     // Bus reset, active low
  logic [2:0] card_system_error_sync_q, card_system_error_sync_d;   // Card SERR, active low
  logic       pci_reset_in_n_q, pci_reset_in_n_d;           // Filtered bus reset
  logic       card_system_error_n_q, card_system_error_n_d;         // Filtered card SERR
  logic       card_system_error_n_old_q, card_system_error_n_old_d; // For edge detect

  // Next values: a level is taken once stages two and three agree
  always_comb begin
    pci_reset_in_sync_d   = {pci_reset_in_sync_q[1:0], pci_reset_in_n_i};
    card_system_error_sync_d  = {card_system_error_sync_q[1:0], card_system_error_n_i};
    pci_reset_in_n_d      = pci_reset_in_n_q;
    card_system_error_n_d     = card_system_error_n_q;
    card_system_error_n_old_d = card_system_error_n_q;
    if (pci_reset_in_sync_q[1] == pci_reset_in_sync_q[2]) begin
      pci_reset_in_n_d = pci_reset_in_sync_q[2];
    end
    if (card_system_error_sync_q[1] == card_system_error_sync_q[2]) begin
      card_system_error_n_d = card_system_error_sync_q[2];
    end
  end

  // Synchroniser flops; idle high so no false event at start
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pci_reset_in_sync_q   <= 3'h7;
      card_system_error_sync_q  <= 3'h7;
      pci_reset_in_n_q      <= 1'b1;
      card_system_error_n_q     <= 1'b1;
      card_system_error_n_old_q <= 1'b1;
    end else begin
      pci_reset_in_sync_q   <= pci_reset_in_sync_d;
      card_system_error_sync_q  <= card_system_error_sync_d;
      pci_reset_in_n_q      <= pci_reset_in_n_d;
      card_system_error_n_q     <= card_system_error_n_d;
      // Last cycle's filtered level, so a fall is seen for one cycle
      card_system_error_n_old_q <= card_system_error_n_old_d;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  logic [7:0]  line_q, line_d;   // Interrupt line number
  logic [15:0] bctl_q, bctl_d;   // Bridge control
  logic        hit;              // Access targets our dword
  logic [15:0] bctl_wr;          // Write data for bridge control

  // Pin code of the CardBus function is a constant
  function automatic logic [7:0] pin_read();
    pin_read = `CBR_PIN_INTA; // R2
  endfunction

  assign hit = (cfg_req_i.addr & `CBR_DWORD_MASK) == `CBR_OFF_LINE;

  // Byte lanes 2 and 3 carry bridge control; other lanes keep old
  always_comb begin
    bctl_wr = bctl_q;
    if (cfg_req_i.be[2]) begin
      bctl_wr[7:0] = cfg_req_i.wdata[23:16];
    end
    if (cfg_req_i.be[3]) begin
      bctl_wr[15:8] = cfg_req_i.wdata[31:24];
    end
  end

  // Next values of the stored registers
  always_comb begin
    line_d = line_q;
    bctl_d = bctl_q;
    if (!pci_reset_in_n_q) begin
      // Bus reset restores defaults, except the card reset bit
      // while power management keeps its context
      line_d = `CBR_LINE_RST;
      bctl_d = `CBR_BCTL_RST;
      if (pme_enable_i) begin
        bctl_d[`CBR_B_CARDBUS_RESET_OUT] = bctl_q[`CBR_B_CARDBUS_RESET_OUT]; // R12
      end
    end else if (cfg_req_i.wr && hit) begin
      if (cfg_req_i.be[0]) begin
        line_d = cfg_req_i.wdata[7:0]; // R1
      end
      // Lane 1 is the read-only pin byte and is dropped
      // Reserved and read-only bits never take write data
      bctl_d = (bctl_wr & `CBR_BCTL_WMASK) |
               (bctl_q & ~`CBR_BCTL_WMASK); // R19 R6
    end
  end

  // Global reset is the only reset that always clears everything
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_q <= `CBR_LINE_RST; // R1
      bctl_q <= `CBR_BCTL_RST; // R6 R12
    end else begin
      line_q <= line_d;
      bctl_q <= bctl_d;
    end
  end

  // ****************************************************************
  // Configuration read port
  // ****************************************************************

  logic [31:0] rdata_q, rdata_d; // Registered read data
  logic        ack_q, ack_d;     // One-cycle completion

  // Answer one cycle after any strobe; other dwords read zero
  always_comb begin
    ack_d   = cfg_req_i.rd || cfg_req_i.wr;
    rdata_d = 32'h0;
    if (cfg_req_i.rd && hit) begin
      rdata_d = {bctl_q & `CBR_BCTL_WMASK, pin_read(), line_q}; // R6
    end
  end

  // Read port flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0;
      ack_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_ack_o   = ack_q;

  // ****************************************************************
  // Interrupt merge and routing
  // ****************************************************************

  logic [3:0] pint_q, pint_d;     // Merged interrupt lines
  logic       legacy_q, legacy_d; // Legacy routed interrupt
  logic [7:0] spin_q, spin_d;     // Smart card pin code

  // Card functional interrupt joins line A unless routed legacy
  always_comb begin
    logic [3:0] src;
    src = int_src_i;
    legacy_d = 1'b0;
    if (bctl_q[`CBR_B_ROUTE]) begin
      legacy_d = func_irq_i; // R9
    end else begin
      src[0] = int_src_i[0] | func_irq_i; // R9
    end
    pint_d = src;
    if (tie_all_interrupts_i) begin
      pint_d = {3'b000, |src}; // R4
    end else if (tie_b_to_a_i) begin
      pint_d = {src[3:2], 1'b0, src[0] | src[1]}; // R3
    end
    // Select field holds the pin number less one
    if (tie_all_interrupts_i) begin
      spin_d = `CBR_PIN_INTA; // R4
    end else begin
      spin_d = {6'h00, smart_int_sel_i} + `CBR_PIN_INTA; // R5
    end
  end

  // Interrupt flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pint_q   <= 4'h0;
      legacy_q <= 1'b0;
      spin_q   <= `CBR_PIN_INTA;
    end else begin
      pint_q   <= pint_d;
      legacy_q <= legacy_d;
      spin_q   <= spin_d;
    end
  end

  assign pci_int_o            = pint_q;
  assign legacy_irq_o         = legacy_q;
  assign interrupt_pin_code_o = spin_q;

  // ****************************************************************
  // Bridge controls and error reporting
  // ****************************************************************

  logic       cardbus_reset_out_q, cardbus_reset_out_d;   // Card reset, active low level
  logic       post_q, post_d;   // Posting decision
  logic [1:0] pf_q, pf_d;       // Window prefetch types
  logic       tabt_q, tabt_d;   // Target abort pulse
  logic       serr_q, serr_d;   // System error pulse
  logic       perr_q, perr_d;   // Parity pin drive
  logic       claim_q, claim_d; // Registered claim
  logic       card_system_error_fall;       // New card system error

  assign card_system_error_fall = card_system_error_n_old_q && !card_system_error_n_q;

  // Control outputs follow register bits one cycle later
  always_comb begin
    // Bus reset drives the card reset whatever the bit says
    cardbus_reset_out_d = !(bctl_q[`CBR_B_CARDBUS_RESET_OUT] || !pci_reset_in_n_q); // R10 R11
    // Single writes are never posted; only bursts may be
    post_d = bctl_q[`CBR_B_POST] && burst_write_i; // R7
    pf_d   = bctl_q[`CBR_B_PF1:`CBR_B_PF0]; // R8
    tabt_d = master_abort_i && bctl_q[`CBR_B_MABORT]; // R13
    serr_d = serr_enable_i &&
             (tabt_d || // R13
              (card_system_error_fall && bctl_q[`CBR_B_SYSERR])); // R16
    perr_d = parity_err_det_i && bctl_q[`CBR_B_PARITY]; // R17
  end

  // Output flops; card held in reset while global reset is low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cardbus_reset_out_q  <= 1'b0;
      post_q  <= 1'b0;
      pf_q    <= 2'b11;
      tabt_q  <= 1'b0;
      serr_q  <= 1'b0;
      perr_q  <= 1'b0;
      claim_q <= 1'b0;
    end else begin
      cardbus_reset_out_q  <= cardbus_reset_out_d;
      post_q  <= post_d;
      pf_q    <= pf_d;
      tabt_q  <= tabt_d;
      serr_q  <= serr_d;
      perr_q  <= perr_d;
      claim_q <= claim_d;
    end
  end

  // Address claim decode, registered before leaving the block
  cbr_claim u_claim (
    .acc_i    (acc_i),
    .win0_i   (win0_i),
    .win1_i   (win1_i),
    .vga_en_i (bctl_q[`CBR_B_VGA]), // R14
    .isa_en_i (bctl_q[`CBR_B_ISA]), // R15
    .claim_o  (claim_d)
  );

  assign cardbus_reset_out_n_o  = cardbus_reset_out_q;
  assign post_write_o           = post_q;
  assign window_prefetch_o      = pf_q;
  assign target_abort_o         = tabt_q;
  assign pci_serr_o             = serr_q;
  // Open-drain style: low level, driven only while reporting
  assign card_parity_error_o    = 1'b0;
  assign card_parity_error_oe_o = perr_q;
  assign claim_o                = claim_q;

endmodule

`default_nettype wire

/* File: cbr_consts.svh */
`ifndef CBR_CONSTS_SVH
`define CBR_CONSTS_SVH

// ****************************************************************
// Configuration offsets (byte addresses)
// ****************************************************************
`define CBR_OFF_LINE     8'h3C
`define CBR_OFF_PIN      8'h3D
`define CBR_OFF_BCTL     8'h3E
`define CBR_DWORD_MASK   8'hFC

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define CBR_LINE_RST     8'hFF
`define CBR_PIN_INTA     8'h01
`define CBR_BCTL_RST     16'h0340
`define CBR_BCTL_WMASK   16'h07EF

// ****************************************************************
// Bridge control field positions
// ****************************************************************
`define CBR_B_PARITY     0
`define CBR_B_SYSERR     1
`define CBR_B_ISA        2
`define CBR_B_VGA        3
`define CBR_B_MABORT     5
`define CBR_B_CARDBUS_RESET_OUT       6
`define CBR_B_ROUTE      7
`define CBR_B_PF0        8
`define CBR_B_PF1        9
`define CBR_B_POST       10

// ****************************************************************
// Address decode constants
// ****************************************************************
`define CBR_ISA_TOP      32'h0000FFFF
`define CBR_ISA_LOW_MASK 32'h00000300
`define CBR_VGA_MEM_LO   32'h000A0000
`define CBR_VGA_MEM_HI   32'h000BFFFF
`define CBR_VGA_IO_A_LO  10'h3B0
`define CBR_VGA_IO_A_HI  10'h3BB
`define CBR_VGA_IO_B_LO  10'h3C0
`define CBR_VGA_IO_B_HI  10'h3DF
`define CBR_WIN_LOW_BITS 32'h00000FFF

`endif

/* File: cbr_pkg.sv */
package cbr_pkg;

  // ****************************************************************
  // Configuration request from the host side
  // ****************************************************************
  typedef struct packed {
    logic        rd;     // Read strobe, one cycle
    logic        wr;     // Write strobe, one cycle
    logic [7:0]  addr;   // Byte address
    logic [3:0]  be;     // Byte enables
    logic [31:0] wdata;  // Write data
  } cbr_cfg_req_s;

  // ****************************************************************
  // Bridge-side access presented for claim decode
  // ****************************************************************
  typedef struct packed {
    logic        valid;  // Access present this cycle
    logic        is_io;  // I/O when 1, memory when 0
    logic [31:0] addr;   // Access address
  } cbr_access_s;

  // Memory window base and limit pair
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
  } cbr_window_s;

endpackage

/* File: cbr_claim.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cbr_consts.svh"

// Decides whether a bridge-side access is passed to the card socket
module cbr_claim
  import cbr_pkg::*;
(
  input  wire cbr_access_s acc_i,      // Access under test
  input  wire cbr_window_s win0_i,     // Memory window 0
  input  wire cbr_window_s win1_i,     // Memory window 1
  input  wire logic        vga_en_i,   // VGA forwarding enabled
  input  wire logic        isa_en_i,   // ISA alias filter enabled
  output logic             claim_o     // Access goes to the socket
);

  // ****************************************************************
  // Window hit: a window with zero base and limit stays closed
  // ****************************************************************
  function automatic logic win_hit(input cbr_window_s w,
                                   input logic [31:0] a);
    logic open;
    open = (w.base != 32'h0) || (w.limit != 32'h0); // R18
    win_hit = open && (a >= w.base) &&
              (a <= (w.limit | `CBR_WIN_LOW_BITS));
  endfunction

  // ****************************************************************
  // Combined decode
  // ****************************************************************
  always_comb begin
    logic vga;
    logic isa_alias;
    vga = 1'b0;
    isa_alias = 1'b0;
    // Legacy display ranges, memory and I/O
    if (!acc_i.is_io) begin
      vga = (acc_i.addr >= `CBR_VGA_MEM_LO) &&
            (acc_i.addr <= `CBR_VGA_MEM_HI);
    end else begin
      vga = ((acc_i.addr[9:0] >= `CBR_VGA_IO_A_LO) &&
             (acc_i.addr[9:0] <= `CBR_VGA_IO_A_HI)) ||
            ((acc_i.addr[9:0] >= `CBR_VGA_IO_B_LO) &&
             (acc_i.addr[9:0] <= `CBR_VGA_IO_B_HI));
    end
    // Upper 768 bytes of each 1K block in the first 64K of I/O
    isa_alias = acc_i.is_io && (acc_i.addr <= `CBR_ISA_TOP) &&
                ((acc_i.addr & `CBR_ISA_LOW_MASK) != 32'h0);
    if (!acc_i.valid) begin
      claim_o = 1'b0;
    end else if (vga_en_i && vga) begin
      claim_o = 1'b1; // R14
    end else if (acc_i.is_io) begin
      // I/O windows live elsewhere; only the alias filter acts here
      claim_o = !(isa_en_i && isa_alias); // R15
    end else begin
      claim_o = win_hit(win0_i, acc_i.addr) ||
                win_hit(win1_i, acc_i.addr);
    end
  end

endmodule

`default_nettype wire

/* File: cbr_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// ********
// Port checker for the bridge register block
// ********
module cbr_regs_assertions
  import cbr_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         nrst_i,
  input wire logic         pci_reset_in_n_i,
  input wire cbr_cfg_req_s cfg_req_i,
  input wire logic [31:0]  cfg_rdata_o,
  input wire logic         cfg_ack_o,
  input wire logic         tie_b_to_a_i,
  input wire logic         tie_all_interrupts_i,
  input wire logic [1:0]   smart_int_sel_i,
  input wire logic [3:0]   int_src_i,
  input wire logic [3:0]   pci_int_o,
  input wire logic [7:0]   interrupt_pin_code_o,
  input wire logic         cardbus_reset_out_n_o,
  input wire logic         master_abort_i,
  input wire logic         serr_enable_i,
  input wire logic         target_abort_o,
  input wire logic         pci_serr_o,
  input wire cbr_access_s  acc_i,
  input wire logic         claim_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Every access is answered one cycle later, refused ones too
  a_ack_next: assert property (
    (cfg_req_i.rd || cfg_req_i.wr) |=> cfg_ack_o)
    else $error("config access not answered");
  a_pin_inta: assert property (
    cfg_req_i.rd && cfg_req_i.addr[7:2] == 6'h0F
    |=> cfg_rdata_o[15:8] == 8'h01) else $error("pin byte not 01");
  // Reserved bridge bits read zero on every answer
  a_rsvd_zero: assert property (
    cfg_ack_o |-> cfg_rdata_o[31:27] == 5'h00 && !cfg_rdata_o[20])
    else $error("reserved bits not zero");
  a_tie_b_merge: assert property (
    tie_b_to_a_i && int_src_i[1] |=> pci_int_o[0])
    else $error("B not merged onto A");
  // C and D are never touched unless everything is tied
  a_cd_keep: assert property (
    !tie_all_interrupts_i |=> pci_int_o[3:2] == $past(int_src_i[3:2]))
    else $error("C or D line altered");
  a_tie_all: assert property (
    tie_all_interrupts_i |=> interrupt_pin_code_o == 8'h01
    && (pci_int_o[0] || !$past(|int_src_i)))
    else $error("tie all not honoured");
  a_pin_sel: assert property (
    !tie_all_interrupts_i |=> interrupt_pin_code_o ==
    {6'h00, $past(smart_int_sel_i)} + 8'h01)
    else $error("pin code not from select");
  // Synchroniser plus output flop fit in six cycles
  a_bus_rst_card: assert property (
    !pci_reset_in_n_i [*6] |-> !cardbus_reset_out_n_o)
    else $error("card reset not held in bus reset");
  a_abort_cause: assert property (
    target_abort_o |-> $past(master_abort_i))
    else $error("target abort without cause");
  a_abort_serr: assert property (
    target_abort_o && $past(serr_enable_i) |-> pci_serr_o)
    else $error("abort not signalled as system error");
  a_claim_cause: assert property (
    claim_o |-> $past(acc_i.valid)) else $error("claim without access");

  c_abort: cover property (target_abort_o);
  c_claim: cover property (claim_o);
  c_card_free: cover property ($rose(cardbus_reset_out_n_o));
endmodule

bind cbr_regs cbr_regs_assertions u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .pci_reset_in_n_i(pci_reset_in_n_i),
  .cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
  .tie_b_to_a_i(tie_b_to_a_i), .tie_all_interrupts_i(tie_all_interrupts_i),
  .smart_int_sel_i(smart_int_sel_i), .int_src_i(int_src_i),
  .pci_int_o(pci_int_o), .interrupt_pin_code_o(interrupt_pin_code_o),
  .cardbus_reset_out_n_o(cardbus_reset_out_n_o),
  .master_abort_i(master_abort_i), .serr_enable_i(serr_enable_i),
  .target_abort_o(target_abort_o), .pci_serr_o(pci_serr_o),
  .acc_i(acc_i), .claim_o(claim_o)
);

`default_nettype wire

/* File: cbr_socket_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ********
// Card socket model: drives the system error pin
// ********
module cbr_socket_model (
  input  wire logic clk_i,                 // Bus clock
  input  wire logic nrst_i,                // Global reset
  input  wire logic serr_req_i,            // Bench asks for an error
  output logic      card_system_error_n_o  // Pulled-up error pin
);
  logic [1:0] hold_q;  // Cycles left with the pin low
  logic [1:0] hold_d;  // Next count

  // Three low cycles per request, long enough for the synchroniser
  always_comb begin
    hold_d = (hold_q != 2'h0) ? hold_q - 2'h1 : hold_q;
    if (serr_req_i) begin
      hold_d = 2'h3;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_q <= 2'h0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // Released pin goes back high through the pull-up
  assign card_system_error_n_o = (hold_q == 2'h0);
endmodule

`default_nettype wire

/* File: cbr_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("unexpected %0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end

// ********
// Bench for the bridge register block
// ********
module cbr_regs_bench
  import cbr_pkg::*;
;
  logic         clk = 1'b0, nrst = 1'b0, bus_rst_n = 1'b1;
  logic         tie_b = 1'b0, tie_all = 1'b0, pm_en = 1'b0;
  logic         burst = 1'b0, serr_en = 1'b0, func_irq = 1'b0;
  logic [2:0]   ev = 3'h0;     // Parity, card error, master abort
  logic [1:0]   sel = 2'h0;    // Smart card select
  logic [3:0]   src = 4'h0;    // Interrupt sources A..D
  cbr_cfg_req_s req = '0;      // Config request
  cbr_access_s  acc = '0;      // Access for claim decode
  cbr_window_s  win0 = '0, win1 = '0;
  logic [31:0]  rdata;
  logic [3:0]   ints;
  logic [7:0]   pin;
  logic [1:0]   pf;
  logic         ack, legacy, card_rst_n, post, ta, serr, par_oe, claim;
  logic         par_lvl;       // Parity pin level, driven low only
  logic         card_serr_n;   // Pin driven by the socket model
  logic [2:0]   seen = 3'h0;   // Sticky {parity oe, serr, abort}
  int           err_count = 0, num_checks = 0, cyc = 0;

  cbr_regs u_dut (
    .clk_i(clk), .nrst_i(nrst), .pci_reset_in_n_i(bus_rst_n),
    .cfg_req_i(req), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
    .tie_b_to_a_i(tie_b), .tie_all_interrupts_i(tie_all),
    .smart_int_sel_i(sel), .pme_enable_i(pm_en), .int_src_i(src),
    .func_irq_i(func_irq), .pci_int_o(ints), .legacy_irq_o(legacy),
    .interrupt_pin_code_o(pin), .cardbus_reset_out_n_o(card_rst_n),
    .burst_write_i(burst), .post_write_o(post),
    .window_prefetch_o(pf), .master_abort_i(ev[0]),
    .serr_enable_i(serr_en), .target_abort_o(ta), .pci_serr_o(serr),
    .card_system_error_n_i(card_serr_n), .parity_err_det_i(ev[2]),
    .card_parity_error_o(par_lvl), .card_parity_error_oe_o(par_oe),
    .acc_i(acc), .win0_i(win0), .win1_i(win1), .claim_o(claim)
  );

  cbr_socket_model u_sock (
    .clk_i(clk), .nrst_i(nrst), .serr_req_i(ev[1]),
    .card_system_error_n_o(card_serr_n)
  );

  always #2 clk = ~clk;

  // Pulses are short, so they are caught in sticky flags
  always @(posedge clk) begin
    seen <= seen | {par_oe, serr, ta};
  end

  // Hang guard, far above the roughly 180 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Wait n edges, then look mid-cycle where outputs are settled
  task automatic nx(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // One access; returns in the middle of the answer cycle
  task automatic cfg(input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    req <= {~w, w, a, be, d};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    `CHK(ack, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    cfg(1'b0, a, 4'hF, 32'h0000_0000);
    `CHK(rdata, e);
  endtask

  // Bridge control through the two upper lanes, outputs settled after
  task automatic setb(input logic [15:0] v);
    cfg(1'b1, 8'h3C, 4'hC, {v, 16'h0000});
    nx(1);
  endtask

  task automatic pulse(input logic [2:0] k);
    seen = 3'h0;
    @(posedge clk);
    ev <= k;
    @(posedge clk);
    ev <= 3'h0;
    nx(6);
  endtask

  task automatic clm(input logic [15:0] v, input logic io,
                     input logic [31:0] a, input logic e);
    setb(v);
    @(posedge clk);
    acc <= {1'b1, io, a};
    nx(1);
    `CHK(claim, e);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    nx(1);
    `CHK({pf, card_rst_n, pin}, 11'h601);
    rd(8'h3C, 32'h0340_01FF);
    cfg(1'b1, 8'h3C, 4'hF, 32'hFFFF_AA12);
    rd(8'h3C, 32'h07EF_0112);
    cfg(1'b1, 8'h40, 4'hF, 32'h1234_5678);
    rd(8'h40, 32'h0000_0000);
    setb(16'h0000);
    `CHK({pf, card_rst_n}, 3'b001);
    rd(8'h3C, 32'h0000_0112);
    @(posedge clk);
    {burst, func_irq, serr_en} <= 3'b111;
    nx(1);
    `CHK({post, ints[0], legacy}, 3'b010);
    setb(16'h0480);
    `CHK({post, ints[0], legacy}, 3'b101);
    // Error paths, first with all responses off, then on
    for (int b = 0; b < 2; b++) begin
      setb(b ? 16'h0023 : 16'h0000);
      pulse(3'b001);
      `CHK(seen, b ? 3'b011 : 3'b000);
      pulse(3'b010);
      `CHK(seen, b ? 3'b010 : 3'b000);
      pulse(3'b100);
      `CHK(seen, b ? 3'b100 : 3'b000);
    end
    `CHK(par_lvl, 1'b0);
    clm(16'h0008, 1'b0, 32'h000A_0000, 1'b1);
    clm(16'h0000, 1'b0, 32'h000A_0000, 1'b0);
    clm(16'h0004, 1'b1, 32'h0000_0100, 1'b0);
    clm(16'h0004, 1'b1, 32'h0000_0010, 1'b1);
    clm(16'h0000, 1'b1, 32'h0000_0100, 1'b1);
    @(posedge clk);
    win0 <= {32'h0010_0000, 32'h0010_0000};
    clm(16'h0000, 1'b0, 32'h0010_0800, 1'b1);
    // Second window open too; an address past window 0's limit and below window 1's base misses
    @(posedge clk);
    win1 <= {32'h0020_0000, 32'h0020_0000};
    clm(16'h0000, 1'b0, 32'h0020_0FFC, 1'b1);
    clm(16'h0000, 1'b0, 32'h0010_1000, 1'b0);
    @(posedge clk);
    {func_irq, src} <= 5'b0_0110;
    nx(1);
    `CHK(ints, 4'b0110);
    @(posedge clk);
    {tie_b, src} <= 5'b1_0010;
    nx(1);
    `CHK(ints, 4'b0001);
    // Every select value, without and with the tie-all merge
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      {tie_all, sel} <= s[2:0];
      src <= 4'b1000;
      nx(1);
      `CHK(pin, s[2] ? 8'h01 : {6'h00, s[1:0]} + 8'h01);
    end
    `CHK(ints[0], 1'b1);
    // Bus reset with power events on keeps the card reset bit
    for (int p = 1; p >= 0; p--) begin
      setb(16'h0000);
      @(posedge clk);
      {pm_en, bus_rst_n} <= {p[0], 1'b0};
      nx(8);
      `CHK(card_rst_n, 1'b0);
      @(posedge clk);
      bus_rst_n <= 1'b1;
      nx(6);
      rd(8'h3C, p ? 32'h0300_01FF : 32'h0340_01FF);
    end
    print_verdict();
  end
endmodule

`default_nettype wire
